// ### src/serial_cmd_pkg.sv
package serial_cmd_pkg;
    // command block word positions
    localparam logic [3:0]  IDX_LEN       = 4'h0;
    localparam logic [3:0]  IDX_TYPE      = 4'h2;
    localparam logic [3:0]  IDX_ADDR      = 4'h3;
    localparam logic [3:0]  IDX_CMD       = 4'h6;
    localparam logic [3:0]  IDX_ARG0      = 4'h7;
    localparam logic [3:0]  IDX_ARG1      = 4'h8;
    localparam logic [16:0] HDR_EXTRA     = 17'h00005;
    // command numbers (decimal 4301..4304)
    localparam logic [15:0] CMD_BUF_SIZE  = 16'h10cd;
    localparam logic [15:0] CMD_FLUSH     = 16'h10ce;
    localparam logic [15:0] CMD_STATUS    = 16'h10cf;
    localparam logic [15:0] CMD_PORT_CTRL = 16'h10d0;
    // completion codes written to the block's status location
    localparam logic [15:0] CODE_OK       = 16'h0001;
    localparam logic [15:0] CODE_ERR_LEN  = 16'h0002;
    localparam logic [15:0] CODE_ERR_CMD  = 16'h0003;
    localparam logic [15:0] CODE_RESET    = 16'h0000;
    // receive buffer default capacity in bytes
    localparam int          DEF_BUF_BYTES = 2048;
    // port status word bit positions
    localparam int          BIT_RD_PEND   = 15;
    localparam int          BIT_RD_OK     = 14;
    localparam int          BIT_RD_TMO    = 13;
    localparam int          BIT_WR_PEND   = 12;
    localparam int          BIT_WR_OK     = 11;
    localparam int          BIT_WR_TMO    = 10;
    localparam int          BIT_UNREAD    = 9;
    localparam int          BIT_OVERRUN   = 8;
    localparam int          BIT_FRAME     = 7;
    localparam int          BIT_PARITY    = 6;
    localparam int          BIT_CTS       = 5;
    // port control word
    localparam int          CTRL_RTS_BIT  = 15;
    // reset values
    localparam logic        RTS_RESET     = 1'b0;
    localparam logic [5:0]  OPFLAGS_RESET = 6'h00;
    localparam logic [2:0]  ERRFLAGS_RESET = 3'h0;

    typedef enum logic [2:0] {ST_COLLECT, ST_EXEC, ST_WR_STS, ST_WR_CNT, ST_WR_CODE} cmd_state_e;
endpackage : serial_cmd_pkg

// ### src/serial_port_command_status_unit.sv
// Overview of operation
// - block header: length, mode, status location, command
// - buffer-size command resizes buffer, length in words
// - zero length selects default 2K bytes
// - length over 2K bytes reports error
// - flush command empties receive buffer
// - status command writes status word, then count
// - read and write completion reported independently
// - bit 15 tracks read in progress
// - bits 14/13 read success/timeout, cleared on start
// - bit 12 tracks write in progress
// - bits 11/10 write success/timeout, cleared on start
// - bit 9 high while unread characters remain
// - bits 8/7/6 sticky errors, cleared by status read
// - bit 5 shows clear-to-send or no such input
// - unused low status bits read zero
// - port control command forces request-to-send output
// - only control bit 15 selects request-to-send
// - characters into full buffer dropped, overflow set
// - one asserts request-to-send, zero deasserts
module serial_port_command_status_unit #(
    parameter int BUF_BYTES = serial_cmd_pkg::DEF_BUF_BYTES,
    parameter bit HAS_CTS   = 1'b1
) (
    input  wire logic        i_clk,          // 100 MHz clock
    input  wire logic        i_rstn,         // async reset, active low
    input  wire logic        i_cmd_valid,    // command word offered
    input  wire logic [15:0] i_cmd_word,     // command block word
    output logic             o_cmd_ready,    // command word taken
    output logic             o_wr_valid,     // memory write request
    output logic [15:0]      o_wr_type,      // destination memory type
    output logic [15:0]      o_wr_addr,      // destination address
    output logic [15:0]      o_wr_data,      // word to write
    input  wire logic        i_wr_ready,     // write accepted
    input  wire logic        i_rx_valid,     // received character strobe
    input  wire logic [7:0]  i_rx_char,      // received character
    input  wire logic        i_rx_overrun,   // line overrun strobe
    input  wire logic        i_rx_frame_err, // framing error strobe
    input  wire logic        i_rx_parity_err,// parity error strobe
    input  wire logic        i_take,         // read engine takes a character
    output logic             o_take_valid,   // taken character valid
    output logic [7:0]       o_take_char,    // taken character
    input  wire logic        i_read_start,   // read operation started
    input  wire logic        i_read_done,    // read finished ok
    input  wire logic        i_read_timeout, // read timed out
    input  wire logic        i_read_cancel,  // read cancelled
    input  wire logic        i_write_start,  // write operation started
    input  wire logic        i_write_done,   // write finished ok
    input  wire logic        i_write_timeout,// write timed out
    input  wire logic        i_write_cancel, // write cancelled
    input  wire logic        i_cts,          // clear-to-send pin, high active
    output logic             o_rts           // request-to-send output
);
    localparam int PW = $clog2(BUF_BYTES);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] CAP_MAX = CW'(BUF_BYTES);

    if (BUF_BYTES < 2 || BUF_BYTES > serial_cmd_pkg::DEF_BUF_BYTES || (1 << PW) != BUF_BYTES) begin : g_chk
        $error("BUF_BYTES must be a power of two from 2 to the default capacity");
    end

    function automatic logic [15:0] status_word(input logic [5:0] op, input logic unread,
                                                input logic [2:0] err, input logic cts);
        status_word = {op, unread, err, cts, 5'h00};
    endfunction : status_word

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // cts pin synchroniser
    logic cts_s1_q, cts_s2_q;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cts_s1_q <= 1'b0;
            cts_s2_q <= 1'b0;
        end else begin
            cts_s1_q <= i_cts;
            cts_s2_q <= cts_s1_q;
        end
    end
    logic cts_bit;
    assign cts_bit = HAS_CTS ? cts_s2_q : 1'b1;

    // command interpreter
    serial_cmd_pkg::cmd_state_e state_q, state_d;
    logic [16:0] idx_q, idx_d;
    logic [15:0] len_q, len_d, type_q, type_d, addr_q, addr_d, cmd_q, cmd_d;
    logic [15:0] arg0_q, arg0_d, arg1_q, arg1_d, code_q, code_d, cnt_snap_q, cnt_snap_d;
    logic        ready_q, ready_d, wv_q, wv_d;
    logic [15:0] wt_q, wt_d, wa_q, wa_d, wdat_q, wdat_d;
    logic        flush, clr_err, set_cap, set_rts, last_word;
    logic [CW-1:0] new_cap;
    logic [16:0] req_bytes;
    logic [CW-1:0] count_q, cap_q;
    logic [5:0]  op_q;
    logic [2:0]  err_q;
    logic        rts_q;

    // words to bytes; widened first so a set top bit still counts as oversize
    assign req_bytes = {arg0_q, 1'b0};
    assign last_word = (idx_q != 17'h0) && (idx_q == {1'b0, len_q} + serial_cmd_pkg::HDR_EXTRA);

    always_comb begin
        state_d = state_q; idx_d = idx_q; len_d = len_q; type_d = type_q; addr_d = addr_q;
        cmd_d = cmd_q; arg0_d = arg0_q; arg1_d = arg1_q; code_d = code_q; cnt_snap_d = cnt_snap_q;
        ready_d = ready_q; wv_d = wv_q; wt_d = wt_q; wa_d = wa_q; wdat_d = wdat_q;
        flush = 1'b0; clr_err = 1'b0; set_cap = 1'b0; set_rts = 1'b0; new_cap = cap_q;
        case (state_q)
            serial_cmd_pkg::ST_COLLECT: begin
                if (i_cmd_valid && ready_q) begin
                    idx_d = idx_q + 17'h1;
                    // long blocks must not alias word 16 and up onto the header
                    if (idx_q[16:4] == 13'h0) begin
                        case (idx_q[3:0])
                            serial_cmd_pkg::IDX_LEN:  len_d  = (i_cmd_word == 16'h0) ? 16'h1 : i_cmd_word;
                            serial_cmd_pkg::IDX_TYPE: type_d = i_cmd_word;
                            serial_cmd_pkg::IDX_ADDR: addr_d = i_cmd_word;
                            serial_cmd_pkg::IDX_CMD:  cmd_d  = i_cmd_word;
                            serial_cmd_pkg::IDX_ARG0: arg0_d = i_cmd_word;
                            serial_cmd_pkg::IDX_ARG1: arg1_d = i_cmd_word;
                            default: ;
                        endcase
                    end
                    if (last_word) begin
                        ready_d = 1'b0;
                        state_d = serial_cmd_pkg::ST_EXEC;
                    end
                end
            end
            serial_cmd_pkg::ST_EXEC: begin
                code_d  = serial_cmd_pkg::CODE_OK;
                state_d = serial_cmd_pkg::ST_WR_CODE;
                case (cmd_q)
                    serial_cmd_pkg::CMD_BUF_SIZE: begin
                        if (arg0_q == 16'h0) begin
                            set_cap = 1'b1;
                            new_cap = CAP_MAX;
                        end else if (req_bytes > 17'(BUF_BYTES)) begin
                            code_d = serial_cmd_pkg::CODE_ERR_LEN;
                        end else begin
                            set_cap = 1'b1;
                            new_cap = req_bytes[CW-1:0];
                        end
                    end
                    serial_cmd_pkg::CMD_FLUSH: flush = 1'b1;
                    serial_cmd_pkg::CMD_STATUS: begin
                        clr_err    = 1'b1;
                        cnt_snap_d = 16'(count_q);
                        wdat_d     = status_word(op_q, count_q != '0, err_q, cts_bit);
                        wt_d       = arg0_q;
                        wa_d       = arg1_q;
                        state_d    = serial_cmd_pkg::ST_WR_STS;
                    end
                    serial_cmd_pkg::CMD_PORT_CTRL: set_rts = 1'b1;
                    default: code_d = serial_cmd_pkg::CODE_ERR_CMD;
                endcase
                wv_d = 1'b1;
                if (state_d == serial_cmd_pkg::ST_WR_CODE) begin
                    wt_d   = type_q;
                    wa_d   = addr_q;
                    wdat_d = code_d;
                end
            end
            serial_cmd_pkg::ST_WR_STS: begin
                if (i_wr_ready) begin
                    wa_d    = arg1_q + 16'h1;
                    wdat_d  = cnt_snap_q;
                    state_d = serial_cmd_pkg::ST_WR_CNT;
                end
            end
            serial_cmd_pkg::ST_WR_CNT: begin
                if (i_wr_ready) begin
                    wt_d    = type_q;
                    wa_d    = addr_q;
                    wdat_d  = code_q;
                    state_d = serial_cmd_pkg::ST_WR_CODE;
                end
            end
            serial_cmd_pkg::ST_WR_CODE: begin
                if (i_wr_ready) begin
                    wv_d    = 1'b0;
                    ready_d = 1'b1;
                    idx_d   = 17'h0;
                    state_d = serial_cmd_pkg::ST_COLLECT;
                end
            end
            default: state_d = serial_cmd_pkg::ST_COLLECT;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= serial_cmd_pkg::ST_COLLECT;
            idx_q <= 17'h0; len_q <= 16'h0; type_q <= 16'h0; addr_q <= 16'h0; cmd_q <= 16'h0;
            arg0_q <= 16'h0; arg1_q <= 16'h0; code_q <= serial_cmd_pkg::CODE_RESET; cnt_snap_q <= 16'h0;
            ready_q <= 1'b1; wv_q <= 1'b0; wt_q <= 16'h0; wa_q <= 16'h0; wdat_q <= 16'h0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d; len_q <= len_d; type_q <= type_d; addr_q <= addr_d; cmd_q <= cmd_d;
            arg0_q <= arg0_d; arg1_q <= arg1_d; code_q <= code_d; cnt_snap_q <= cnt_snap_d;
            ready_q <= ready_d; wv_q <= wv_d; wt_q <= wt_d; wa_q <= wa_d; wdat_q <= wdat_d;
        end
    end

    // receive buffer; shrinking below the fill level keeps stored data, new data is dropped until there is room
    logic [7:0]    mem [BUF_BYTES];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] count_d, cap_d;
    logic          store, take_ok, drop, tv_q, tv_d;
    logic [7:0]    tc_q, tc_d;

    always_comb begin
        take_ok = i_take && (count_q != '0) && !flush;
        store   = i_rx_valid && (count_q < cap_q) && !flush;
        drop    = i_rx_valid && !store && !flush;
        wp_d = wp_q; rp_d = rp_q; count_d = count_q; tc_d = tc_q;
        tv_d = take_ok;
        cap_d = set_cap ? new_cap : cap_q;
        if (flush) begin
            rp_d    = wp_q;
            count_d = '0;
        end else begin
            if (store) wp_d = wp_q + PW'(1);
            if (take_ok) begin
                rp_d = rp_q + PW'(1);
                tc_d = mem[rp_q];
            end
            if (store && !take_ok) count_d = count_q + CW'(1);
            else if (take_ok && !store) count_d = count_q - CW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (store) mem[wp_q] <= i_rx_char;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wp_q <= '0; rp_q <= '0; count_q <= '0; cap_q <= CAP_MAX; tv_q <= 1'b0; tc_q <= 8'h00;
        end else begin
            wp_q <= wp_d; rp_q <= rp_d; count_q <= count_d; cap_q <= cap_d; tv_q <= tv_d; tc_q <= tc_d;
        end
    end

    // status flags: op = {rd_pend, rd_ok, rd_tmo, wr_pend, wr_ok, wr_tmo}, err = {ovr, frame, parity}
    logic [5:0] op_d;
    logic [2:0] err_d;
    logic       rts_d;
    always_comb begin
        op_d = op_q;
        if (i_read_done) op_d[5:3] = {1'b0, 1'b1, op_q[3]};
        if (i_read_timeout) op_d[5:3] = {1'b0, op_d[4], 1'b1};
        if (i_read_cancel) op_d[5] = 1'b0;
        if (i_read_start) op_d[5:3] = 3'b100;
        if (i_write_done) op_d[2:0] = {1'b0, 1'b1, op_q[0]};
        if (i_write_timeout) op_d[2:0] = {1'b0, op_d[1], 1'b1};
        if (i_write_cancel) op_d[2] = 1'b0;
        if (i_write_start) op_d[2:0] = 3'b100;
        // an error arriving with the clearing read survives it
        err_d = (clr_err ? 3'h0 : err_q) | {i_rx_overrun | drop, i_rx_frame_err, i_rx_parity_err};
        rts_d = set_rts ? arg0_q[serial_cmd_pkg::CTRL_RTS_BIT] : rts_q;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            op_q  <= serial_cmd_pkg::OPFLAGS_RESET;
            err_q <= serial_cmd_pkg::ERRFLAGS_RESET;
            rts_q <= serial_cmd_pkg::RTS_RESET;
        end else begin
            op_q  <= op_d;
            err_q <= err_d;
            rts_q <= rts_d;
        end
    end

    assign o_cmd_ready  = ready_q;
    assign o_wr_valid   = wv_q;
    assign o_wr_type    = wt_q;
    assign o_wr_addr    = wa_q;
    assign o_wr_data    = wdat_q;
    assign o_take_valid = tv_q;
    assign o_take_char  = tc_q;
    assign o_rts        = rts_q;

    logic [15:0] sw;
    assign sw = status_word(op_q, count_q != '0, err_q, cts_bit);
    logic exec_buf;
    assign exec_buf = state_q == serial_cmd_pkg::ST_EXEC && cmd_q == serial_cmd_pkg::CMD_BUF_SIZE;

    a_zero_len_default: assert property (exec_buf && arg0_q == 16'h0 |=> cap_q == CAP_MAX)
        else $error("zero buffer length did not select default");
    a_big_len_err: assert property (exec_buf && {arg0_q, 1'b0} > 17'(BUF_BYTES)
        |=> code_q == serial_cmd_pkg::CODE_ERR_LEN && $stable(cap_q) ##1 o_wr_data == serial_cmd_pkg::CODE_ERR_LEN)
        else $error("oversize buffer length not refused");
    a_flush_empty: assert property (flush |=> count_q == '0 && !sw[serial_cmd_pkg::BIT_UNREAD])
        else $error("flush left characters");
    a_status_pair: assert property (state_q == serial_cmd_pkg::ST_WR_STS && i_wr_ready
        |=> o_wr_valid && o_wr_data == cnt_snap_q && o_wr_addr == arg1_q + 16'h1)
        else $error("count word not second");
    a_read_start: assert property (i_read_start |=> sw[15:13] == 3'b100)
        else $error("read start flags wrong");
    a_write_start: assert property (i_write_start |=> sw[12:10] == 3'b100 && $past(sw[15:13]) == sw[15:13]
        || $past(i_read_start | i_read_done | i_read_timeout | i_read_cancel))
        else $error("write start flags wrong");
    a_unread_bit: assert property (state_q == serial_cmd_pkg::ST_WR_STS
        |-> o_wr_data[serial_cmd_pkg::BIT_UNREAD] == (cnt_snap_q != 16'h0) && o_wr_data[4:0] == 5'h00)
        else $error("unread bit or low bits wrong");
    a_err_sticky: assert property (err_q[1] && !clr_err |=> err_q[1])
        else $error("framing flag lost without status read");
    a_drop_full: assert property (i_rx_valid && count_q >= cap_q && !take_ok && !flush
        |=> $stable(count_q) && err_q[2])
        else $error("character stored into full buffer");
    a_rts_follow: assert property (set_rts |=> o_rts == $past(arg0_q[15]))
        else $error("rts not forced");
    a_count_step: assert property (store && !take_ok |=> count_q == $past(count_q) + CW'(1))
        else $error("count not incremented");
    a_code_written: assert property (state_q == serial_cmd_pkg::ST_EXEC && cmd_q != serial_cmd_pkg::CMD_STATUS
        |=> o_wr_valid && o_wr_addr == addr_q && o_wr_type == type_q)
        else $error("completion code not issued");

    c_status_cmd: cover property (state_q == serial_cmd_pkg::ST_WR_CNT && i_wr_ready);
    c_overflow:   cover property (drop);
    c_both_done:  cover property (sw[14] && sw[11]);
    c_resize:     cover property (set_cap && new_cap != CAP_MAX);
endmodule : serial_port_command_status_unit

// ### tb/remote_serial_model.sv
module remote_serial_model (
    input  wire logic       i_clk,      // receiver clock
    output logic            o_rx_valid, // character strobe
    output logic [7:0]      o_rx_char,  // received character
    output logic [2:0]      o_rx_err,   // overrun, frame, parity strobes
    output logic            o_cts       // clear-to-send, high active
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_char  = 8'h5a;
        o_rx_err   = 3'h0;
        o_cts      = 1'b1;
    end
    // data is not held past its strobe, so a stale capture shows up as a wrong char
    task automatic send_char(input logic [7:0] c);
        @(posedge i_clk);
        #1;
        o_rx_valid = 1'b1;
        o_rx_char  = c;
        @(posedge i_clk);
        #1;
        o_rx_valid = 1'b0;
        o_rx_char  = ~c;
    endtask : send_char
    task automatic send_err(input logic [2:0] e);
        @(posedge i_clk);
        #1;
        o_rx_err = e;
        @(posedge i_clk);
        #1;
        o_rx_err = 3'h0;
    endtask : send_err
    task automatic set_cts(input logic v);
        @(posedge i_clk);
        #1;
        o_cts = v;
    endtask : set_cts
endmodule : remote_serial_model

// ### tb/serial_port_command_status_unit_tb_top.sv
module serial_port_command_status_unit_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk, i_rstn, i_cmd_valid, o_cmd_ready, o_wr_valid, i_wr_ready, i_take, o_take_valid, o_rts;
    logic        rx_valid, cts;
    logic [15:0] i_cmd_word, o_wr_type, o_wr_addr, o_wr_data, cts_b;
    logic [7:0]  rx_char, o_take_char, ev;
    logic [2:0]  rx_err;
    logic [47:0] wq[$];
    logic [7:0]  tq[$];
    logic [7:0]  buf_q[$];
    int          err_count, tests_run, cycles, cap;
    logic [7:0]  evs[6] = '{8'h11, 8'h22, 8'h01, 8'h18, 8'h01, 8'hc4};
    logic [5:0]  fls[6] = '{6'h24, 6'h12, 6'h22, 6'h04, 6'h24, 6'h09};

    serial_port_command_status_unit serial_port_command_status_unit_inst (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_cmd_valid(i_cmd_valid), .i_cmd_word(i_cmd_word),
        .o_cmd_ready(o_cmd_ready), .o_wr_valid(o_wr_valid), .o_wr_type(o_wr_type), .o_wr_addr(o_wr_addr),
        .o_wr_data(o_wr_data), .i_wr_ready(i_wr_ready), .i_rx_valid(rx_valid), .i_rx_char(rx_char),
        .i_rx_overrun(rx_err[2]), .i_rx_frame_err(rx_err[1]), .i_rx_parity_err(rx_err[0]), .i_take(i_take),
        .o_take_valid(o_take_valid), .o_take_char(o_take_char), .i_read_start(ev[0]), .i_read_done(ev[1]),
        .i_read_timeout(ev[2]), .i_read_cancel(ev[3]), .i_write_start(ev[4]), .i_write_done(ev[5]),
        .i_write_timeout(ev[6]), .i_write_cancel(ev[7]), .i_cts(cts), .o_rts(o_rts));
    remote_serial_model remote_serial_model_inst (
        .i_clk(i_clk), .o_rx_valid(rx_valid), .o_rx_char(rx_char), .o_rx_err(rx_err), .o_cts(cts));

    task automatic conclude();
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic check_wr(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_wr
    task automatic check_char(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_char
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit
    task automatic run_cmd(input logic [15:0] cmd, input logic [15:0] len, input logic [15:0] a0,
                           input logic [15:0] a1, input logic [15:0] code);
        logic [15:0] w[$];
        int          n;
        w = '{len, 16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom), cmd, a0, a1};
        n = ((len == 16'h0) ? 1 : int'(len)) + 6;
        while (w.size() < n) w.push_back(16'($urandom));
        wq.push_back({w[2], w[3], code});
        for (int i = 0; i < n; i++) begin
            i_cmd_valid = 1'b1;
            i_cmd_word  = w[i];
            while (o_cmd_ready !== 1'b1) begin
                @(posedge i_clk);
                #1;
            end
            @(posedge i_clk);
            #1;
        end
        i_cmd_valid = 1'b0;
        check_bit(o_cmd_ready, 1'b0);
        for (int k = 0; k < 300 && wq.size() != 0; k++) @(posedge i_clk);
        check_bit(wq.size() == 0, 1'b1);
        wq.delete();
        @(posedge i_clk);
        #1;
    endtask : run_cmd
    task automatic status(input logic [15:0] sw, input logic [15:0] cnt);
        logic [15:0] a0, a1;
        a0 = 16'($urandom);
        a1 = 16'($urandom);
        wq.push_back({a0, a1, sw});
        wq.push_back({a0, a1 + 16'h1, cnt});
        run_cmd(serial_cmd_pkg::CMD_STATUS, 16'h3, a0, a1, serial_cmd_pkg::CODE_OK);
    endtask : status
    task automatic rx(input int n);
        logic [7:0] c;
        repeat (n) begin
            c = 8'($urandom);
            if (buf_q.size() < cap) buf_q.push_back(c);
            remote_serial_model_inst.send_char(c);
        end
    endtask : rx
    task automatic take(input logic want);
        i_take = 1'b1;
        if (want) tq.push_back(buf_q.pop_front());
        @(posedge i_clk);
        #1;
        i_take = 1'b0;
        @(posedge i_clk);
        #1;
    endtask : take

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // ready toggles at random so the write port sees back-pressure
    always @(posedge i_clk) begin
        #1;
        i_wr_ready = 1'($urandom_range(0, 1));
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            conclude();
        end
    end
    always @(negedge i_clk) begin
        if (i_rstn === 1'b1 && o_wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
            check_wr({o_wr_type, o_wr_addr, o_wr_data}, (wq.size() != 0) ? wq.pop_front() : 48'h0);
        end
        if (i_rstn === 1'b1 && o_take_valid === 1'b1) begin
            check_char(o_take_char, (tq.size() != 0) ? tq.pop_front() : ~o_take_char);
        end
    end

    initial begin
        void'($urandom(32'h48ac));
        {i_rstn, i_cmd_valid, i_cmd_word, i_wr_ready, i_take, ev} = '0;
        cap   = 2048;
        cts_b = 16'h1 << serial_cmd_pkg::BIT_CTS;
        repeat (5) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        run_cmd(serial_cmd_pkg::CMD_PORT_CTRL, 16'h2, 16'h8000, 16'h0, serial_cmd_pkg::CODE_OK);
        check_bit(o_rts, 1'b1);
        run_cmd(serial_cmd_pkg::CMD_PORT_CTRL, 16'h2, 16'h7fff, 16'h0, serial_cmd_pkg::CODE_OK);
        check_bit(o_rts, 1'b0);
        $display("test port control done");
        status(cts_b, 16'h0);
        rx(3);
        status(cts_b | 16'h0200, 16'h3);
        take(1'b1);
        run_cmd(serial_cmd_pkg::CMD_FLUSH, 16'h1, 16'h0, 16'h0, serial_cmd_pkg::CODE_OK);
        buf_q.delete();
        status(cts_b, 16'h0);
        take(1'b0);
        $display("test receive and flush done");
        run_cmd(serial_cmd_pkg::CMD_BUF_SIZE, 16'h2, 16'd1025, 16'h0, serial_cmd_pkg::CODE_ERR_LEN);
        run_cmd(serial_cmd_pkg::CMD_BUF_SIZE, 16'h2, 16'd1024, 16'h0, serial_cmd_pkg::CODE_OK);
        run_cmd(serial_cmd_pkg::CMD_BUF_SIZE, 16'h2, 16'd2, 16'h0, serial_cmd_pkg::CODE_OK);
        cap = 4;
        rx(6);
        status(cts_b | 16'h0300, 16'h4);
        status(cts_b | 16'h0200, 16'h4);
        repeat (4) take(1'b1);
        run_cmd(serial_cmd_pkg::CMD_BUF_SIZE, 16'h2, 16'd0, 16'h0, serial_cmd_pkg::CODE_OK);
        cap = 2048;
        rx(6);
        status(cts_b | 16'h0200, 16'h6);
        run_cmd(serial_cmd_pkg::CMD_FLUSH, 16'h1, 16'h0, 16'h0, serial_cmd_pkg::CODE_OK);
        buf_q.delete();
        $display("test buffer size done");
        remote_serial_model_inst.send_err(3'b011);
        status(cts_b | 16'h00c0, 16'h0);
        status(cts_b, 16'h0);
        for (int i = 0; i < 6; i++) begin
            ev = evs[i];
            @(posedge i_clk);
            #1;
            ev = 8'h0;
            status(cts_b | {fls[i], 10'h0}, 16'h0);
        end
        $display("test flags done");
        run_cmd(16'h10cc, 16'h1, 16'h0, 16'h0, serial_cmd_pkg::CODE_ERR_CMD);
        remote_serial_model_inst.set_cts(1'b0);
        repeat (4) @(posedge i_clk);
        #1;
        status({6'h09, 10'h0}, 16'h0);
        $display("test clear-to-send done");
        conclude();
    end
endmodule : serial_port_command_status_unit_tb_top
